//--- logic/dma_channel_control_status.sv
// channel operation, status and device configuration for one dma channel
// How it works
// - engine reset bit resets state, flags, config and fifo
// - clear-complete or start clears completion flag
// - fifo flush empties fifo, self-clears
// - abort finishes begun transfers, discards fifo
// - stop lets fifo drain, then halts
// - start write begins transfer after setup
// - completion bit 25 clears on start, sets at end
// - error bit 15 marks ending by error
// - soft abort bit 14 follows abort bit
// - bit 12 shows stop written, not halted
// - completion interrupt marks real halt
// - illegal fifo op recorded, transfer continues
// - bit 9 set on side process error
// - bit 6 mirrors device request line
// - memory-side error code in bits 3:2
// - device-side error code in bits 1:0
// - config register resets to fixed layout
// - request source selects request pacing
// - port width field drives port transfers
`timescale 1ns/100ps
module dma_channel_control_status
  import dma_ctl_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int LONG_DELAY = DELAY_LONG
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // memory-side stream into the fifo
  input wire logic mem_valid,
  output logic mem_ready,
  input wire logic [WIDTH-1:0] mem_data,
  input wire logic mem_last,
  input wire logic mem_err,
  input wire logic [1:0] mem_err_code,
  // device-side stream out of the fifo
  output logic dev_valid,
  input wire logic dev_ready,
  output logic [WIDTH-1:0] dev_data,
  input wire logic dev_err,
  input wire logic [1:0] dev_err_code,
  input wire logic device_request_line,
  input wire logic op_bus_err,
  // configuration fields and completion
  output logic [2:0] retry_limit_field,
  output logic [3:0] address_step_field,
  output logic [1:0] port_width_field,
  input wire logic completion_irq_enable,
  output logic completion_irq
);
  eng_state_t state_q, state_d;
  logic done_q, done_d, err_q, err_d, abort_q, abort_d, stop_q, stop_d;
  logic transfer_error_flag_q, transfer_error_flag_d, flush_q, flush_d;
  logic [1:0] memory_side_error_code_q, memory_side_error_code_d, device_side_error_code_q, device_side_error_code_d, fifo_op_error_code_q, fifo_op_error_code_d;
  logic [15:0] cfg_q, cfg_d;
  logic [13:0] dly_q, dly_d;
  logic [31:0] rdata_q, rdata_d;
  logic req_s1_q, req_s2_q;
  logic cmd_wr, cfg_wr, eng_rst, start_w, abort_w, stop_w, flush_w, clr_w;
  logic fail, fifo_flush, fifo_illegal, req_ok, active;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready, buf_in_ready;
  logic buf_in_valid, buf_empty, fill, last_in;
  logic [WIDTH-1:0] fifo_out_data;
  logic [2:0] src;
  logic [1:0] rate;

  assign cmd_wr = reg_wr && reg_addr == OFF_COMMAND;
  assign cfg_wr = reg_wr && reg_addr == OFF_CONFIG;
  assign eng_rst = cmd_wr && reg_wdata[CMD_ENGINE_RESET];
  assign start_w = cmd_wr && reg_wdata[CMD_START] && !eng_rst;
  assign abort_w = cmd_wr && reg_wdata[CMD_ABORT] && !eng_rst;
  assign stop_w = cmd_wr && reg_wdata[CMD_STOP] && !eng_rst;
  assign flush_w = cmd_wr && reg_wdata[CMD_FIFO_FLUSH];
  assign clr_w = cmd_wr && reg_wdata[CMD_CLEAR_COMPLETE];

  assign src = cfg_q[F_SOURCE_LO +: 3];
  assign rate = cfg_q[F_DELAY_LO +: 2];
  assign retry_limit_field = cfg_q[F_RETRY_LO +: 3];
  assign address_step_field = cfg_q[F_STEP_LO +: 4];
  // port width handed to the transfer logic
  assign port_width_field = cfg_q[F_WIDTH_LO +: 2];

  // ----------------------------------------------------------------
  // data path
  // ----------------------------------------------------------------
  assign active = state_q == ST_RUN;
  assign mem_ready = fifo_in_ready && active && !abort_w && !eng_rst;
  assign fill = mem_valid && mem_ready;
  assign last_in = fill && mem_last;
  // flush on request, on abort and engine reset
  assign fifo_flush = flush_q || abort_w || eng_rst;

  always_comb
  begin
    unique case (src)
      SRC_MAX_RATE: req_ok = 1'b1;
      SRC_LIMITED: req_ok = dly_q == '0;
      SRC_HW_REQUEST: req_ok = req_s2_q;
      default: req_ok = 1'b0;
    endcase
  end

  assign buf_in_valid = fifo_out_valid && req_ok &&
                        (state_q == ST_RUN || state_q == ST_DRAIN);
  assign fifo_out_ready = buf_in_ready && req_ok &&
                          (state_q == ST_RUN || state_q == ST_DRAIN);

  data_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .flush(fifo_flush),
    .in_valid(fill),
    .in_ready(fifo_in_ready),
    .in_data(mem_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .illegal_op(fifo_illegal)
  );

  skid_buffer #(.WIDTH(WIDTH)) u_buf (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(fifo_out_data),
    .out_valid(dev_valid),
    .out_ready(dev_ready),
    .out_data(dev_data),
    .empty(buf_empty)
  );

  // ----------------------------------------------------------------
  // engine sequencing
  // ----------------------------------------------------------------
  assign fail = (mem_err || dev_err) && state_q != ST_IDLE;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (start_w) state_d = ST_RUN;
      ST_RUN:
        if (abort_w) state_d = ST_ABORTING;
        else if (stop_w || last_in) state_d = ST_DRAIN;
      // halt only once the fifo has emptied
      ST_DRAIN:
        if (abort_w) state_d = ST_ABORTING;
        else if (!fifo_out_valid && buf_empty) state_d = ST_IDLE;
      // words already in the buffer finish first
      ST_ABORTING: if (buf_empty) state_d = ST_IDLE;
    endcase
    if (fail)
      state_d = ST_IDLE;
    if (eng_rst)
      state_d = ST_IDLE;
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  always_comb
  begin
    done_d = done_q;
    err_d = err_q;
    abort_d = abort_q;
    stop_d = stop_q;
    transfer_error_flag_d = transfer_error_flag_q;
    memory_side_error_code_d = memory_side_error_code_q;
    device_side_error_code_d = device_side_error_code_q;
    fifo_op_error_code_d = fifo_op_error_code_q;
    flush_d = flush_w;
    // start clears completion and error fields
    if (start_w)
    begin
      done_d = 1'b0;
      err_d = 1'b0;
      abort_d = 1'b0;
      stop_d = 1'b0;
      transfer_error_flag_d = 1'b0;
      memory_side_error_code_d = 2'h0;
      device_side_error_code_d = 2'h0;
      fifo_op_error_code_d = FIFO_OP_ERROR_CODE_FIFO;
    end
    if (clr_w)
      done_d = 1'b0;
    if (abort_w)
      abort_d = 1'b1;
    if (stop_w)
      stop_d = 1'b1;
    // record fifo misuse, transfer goes on
    if (fifo_illegal)
      fifo_op_error_code_d = FIFO_OP_ERROR_CODE_FIFO;
    else if (op_bus_err)
      fifo_op_error_code_d = FIFO_OP_ERROR_CODE_BUS;
    if (fail)
    begin
      err_d = 1'b1;
      transfer_error_flag_d = 1'b1;
      if (mem_err)
        memory_side_error_code_d = mem_err_code;
      if (dev_err)
        device_side_error_code_d = dev_err_code;
    end
    // set wins over clear in the same cycle
    if (state_q != ST_IDLE && state_d == ST_IDLE)
      done_d = 1'b1;
    if (eng_rst)
    begin
      done_d = 1'b0;
      err_d = 1'b0;
      abort_d = 1'b0;
      stop_d = 1'b0;
      transfer_error_flag_d = 1'b0;
      memory_side_error_code_d = 2'h0;
      device_side_error_code_d = 2'h0;
      fifo_op_error_code_d = FIFO_OP_ERROR_CODE_FIFO;
      flush_d = 1'b1;
    end
  end

  assign completion_irq = done_q && completion_irq_enable;

  // ----------------------------------------------------------------
  // config, pacing delay and read-back
  // ----------------------------------------------------------------
  always_comb
  begin
    cfg_d = cfg_q;
    // writable fields, reset layout on engine reset
    if (eng_rst)
      cfg_d = CFG_FIELD_RESET;
    else if (cfg_wr)
      cfg_d = reg_wdata[CFG_FIELD_LO +: 16];
    dly_d = (dly_q != '0) ? dly_q - 1'b1 : dly_q;
    if (buf_in_valid && buf_in_ready)
    begin
      unique case (rate)
        2'h0: dly_d = '0;
        2'h1: dly_d = DELAY_SHORT;
        2'h2: dly_d = DELAY_MID;
        2'h3: dly_d = 14'(LONG_DELAY);
      endcase
    end
    if (eng_rst)
      dly_d = '0;
    rdata_d = rdata_q;
    if (reg_rd)
    begin
      unique case (reg_addr)
        OFF_COMMAND: rdata_d = CMD_FIXED |
          (32'(flush_q) << CMD_FIFO_FLUSH) |
          (32'(abort_q) << CMD_ABORT) | (32'(stop_q) << CMD_STOP) |
          (32'(state_q != ST_IDLE) << CMD_START);
        OFF_CONFIG: rdata_d = {8'h00, cfg_q, CFG_LOW_FIXED};
        OFF_STATE: rdata_d = (32'(done_q) << ST_COMPLETE) |
          (32'(err_q) << ST_ERROR) | (32'(abort_q) << ST_SOFT_ABORT) |
          (32'(stop_q) << ST_STOP_WRITTEN) |
          (32'(fifo_op_error_code_q) << ST_OP_ERR_LO) |
          (32'(transfer_error_flag_q) << ST_XFER_ERR) |
          (32'(req_s2_q) << ST_REQ_LINE) |
          (32'(memory_side_error_code_q) << ST_MEM_ERR_LO) | (32'(device_side_error_code_q) << ST_DEV_ERR_LO);
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end
  assign reg_rdata = rdata_q;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= ST_IDLE;
      done_q <= 1'b0;
      err_q <= 1'b0;
      abort_q <= 1'b0;
      stop_q <= 1'b0;
      transfer_error_flag_q <= 1'b0;
      memory_side_error_code_q <= 2'h0;
      device_side_error_code_q <= 2'h0;
      fifo_op_error_code_q <= FIFO_OP_ERROR_CODE_FIFO;
      flush_q <= 1'b1;
      cfg_q <= CFG_FIELD_RESET;
      dly_q <= '0;
      rdata_q <= 32'h0000_0000;
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      done_q <= done_d;
      err_q <= err_d;
      abort_q <= abort_d;
      stop_q <= stop_d;
      transfer_error_flag_q <= transfer_error_flag_d;
      memory_side_error_code_q <= memory_side_error_code_d;
      device_side_error_code_q <= device_side_error_code_d;
      fifo_op_error_code_q <= fifo_op_error_code_d;
      flush_q <= flush_d;
      cfg_q <= cfg_d;
      dly_q <= dly_d;
      rdata_q <= rdata_d;
      req_s1_q <= device_request_line;
      req_s2_q <= req_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_started;
    start_w && state_q == ST_IDLE && !fail;
  endsequence
  a_start_clears_done: assert property (s_started |=> !done_q && active)
    else $error("start did not clear completion");
  a_engine_reset_idle: assert property (eng_rst |=> state_q == ST_IDLE &&
      !done_q && cfg_q == CFG_FIELD_RESET)
    else $error("engine reset left state");
  a_flush_self_clear: assert property (flush_q && !flush_w && !eng_rst |=>
      !flush_q)
    else $error("flush bit stuck");
  a_abort_discards: assert property (abort_w |=> !fifo_out_valid &&
      state_q != ST_RUN)
    else $error("abort kept fifo data");
  a_drain_before_halt: assert property (state_q == ST_DRAIN &&
      fifo_out_valid && !fail && !eng_rst |=> state_q != ST_IDLE)
    else $error("halted with data left");
  a_done_on_halt: assert property (state_q != ST_IDLE &&
      state_d == ST_IDLE && !eng_rst |=> done_q)
    else $error("completion not set");
  a_error_marks: assert property (fail && !eng_rst |=> err_q && transfer_error_flag_q &&
      done_q)
    else $error("error not recorded");
  a_abort_flag: assert property (abort_w |=> abort_q)
    else $error("soft abort flag missing");
  a_stop_flag: assert property (stop_w |=> stop_q)
    else $error("stop written flag missing");
  a_irq_on_done: assert property (state_q != ST_IDLE &&
      state_d == ST_IDLE && !eng_rst |=>
      completion_irq == completion_irq_enable)
    else $error("no completion interrupt");
  a_req_mirror: assert property (device_request_line [*3] |->
      req_s2_q)
    else $error("request line not mirrored");
  a_errors_hold: assert property (err_q && !start_w && !eng_rst |=>
      err_q && $stable(memory_side_error_code_q))
    else $error("error fields changed");
endmodule

//--- logic/dma_ctl_pkg.sv
// shared offsets, field positions, reset values and timing for the channel
package dma_ctl_pkg;
  // register byte offsets within the register window
  localparam logic [11:0] OFF_COMMAND = 12'h500;
  localparam logic [11:0] OFF_CONFIG = 12'h514;
  localparam logic [11:0] OFF_STATE = 12'h53c;

  // command register bits
  localparam int CMD_ENGINE_RESET = 31;
  localparam int CMD_CLEAR_COMPLETE = 7;
  localparam int CMD_FIFO_FLUSH = 4;
  localparam int CMD_ABORT = 3;
  localparam int CMD_STOP = 2;
  localparam int CMD_START = 0;
  // fixed read-back pattern of the command register
  localparam logic [31:0] CMD_FIXED = 32'h0000_0502;
  localparam logic [31:0] CMD_RESET = 32'h0000_0512;

  // state register bits
  localparam int ST_COMPLETE = 25;
  localparam int ST_ERROR = 15;
  localparam int ST_SOFT_ABORT = 14;
  localparam int ST_STOP_WRITTEN = 12;
  localparam int ST_OP_ERR_LO = 10;
  localparam int ST_XFER_ERR = 9;
  localparam int ST_REQ_LINE = 6;
  localparam int ST_MEM_ERR_LO = 2;
  localparam int ST_DEV_ERR_LO = 0;

  // config register: bits 23..8 writable, low byte fixed
  localparam logic [31:0] CFG_RESET = 32'h0004_0241;
  localparam logic [15:0] CFG_FIELD_RESET = 16'h0402;
  localparam logic [7:0] CFG_LOW_FIXED = 8'h41;
  localparam int CFG_FIELD_LO = 8;
  // positions inside the 16-bit writable field
  localparam int F_RETRY_LO = 13;
  localparam int F_DELAY_LO = 11;
  localparam int F_SOURCE_LO = 8;
  localparam int F_STEP_LO = 2;
  localparam int F_WIDTH_LO = 0;

  // request source encodings
  localparam logic [2:0] SRC_MAX_RATE = 3'h0;
  localparam logic [2:0] SRC_LIMITED = 3'h1;
  localparam logic [2:0] SRC_DISABLED = 3'h2;
  localparam logic [2:0] SRC_HW_REQUEST = 3'h4;

  // fifo operation error codes
  localparam logic [1:0] FIFO_OP_ERROR_CODE_FIFO = 2'h0;
  localparam logic [1:0] FIFO_OP_ERROR_CODE_BUS = 2'h1;

  // request delay limiter, in clock cycles
  localparam logic [13:0] DELAY_SHORT = 14'h0020;
  localparam logic [13:0] DELAY_MID = 14'h0200;
  localparam int DELAY_LONG = 8192;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DRAIN = 2'b11,
    ST_ABORTING = 2'b10
  } eng_state_t;
endpackage

//--- logic/data_fifo.sv
// data fifo between memory side and device side, with flush
`timescale 1ns/100ps
module data_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // misuse: strobe with no room or no data while flush is high
  output logic illegal_op
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign illegal_op = (in_valid && !in_ready && flush) ||
                      (out_ready && !out_valid && flush);

  always_comb
  begin
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (flush)
    begin
      wp_d = '0;
      rp_d = '0;
      cnt_d = '0;
    end
    else
    begin
      if (push)
        wp_d = (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      if (pop)
        rp_d = (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (push && !flush)
      mem_q[wp_q] <= in_data;
  end
endmodule

//--- logic/skid_buffer.sv
// two-entry buffer so a device-side stall loses no word
`timescale 1ns/100ps
module skid_buffer #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic empty
);
  logic [WIDTH-1:0] main_q, main_d, skid_q, skid_d;
  logic mv_q, mv_d, sv_q, sv_d;

  assign in_ready = !sv_q;
  assign out_valid = mv_q;
  assign out_data = main_q;
  assign empty = !mv_q && !sv_q;

  always_comb
  begin
    main_d = main_q;
    skid_d = skid_q;
    mv_d = mv_q;
    sv_d = sv_q;
    if (mv_q && out_ready)
    begin
      mv_d = sv_q;
      main_d = skid_q;
      sv_d = 1'b0;
    end
    if (in_valid && !sv_q)
    begin
      if (mv_d && !(mv_q && out_ready && !sv_q))
      begin
        skid_d = in_data;
        sv_d = 1'b1;
      end
      else
      begin
        main_d = in_data;
        mv_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      main_q <= '0;
      skid_q <= '0;
      mv_q <= 1'b0;
      sv_q <= 1'b0;
    end
    else
    begin
      main_q <= main_d;
      skid_q <= skid_d;
      mv_q <= mv_d;
      sv_q <= sv_d;
    end
  end
endmodule

//--- verification/stream_partner.sv
// far-side model: memory word source and device word sink
`timescale 1ns/100ps
module stream_partner #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // memory side
  output logic mem_valid,
  input wire logic mem_ready,
  output logic [WIDTH-1:0] mem_data,
  output logic mem_last,
  // device side
  input wire logic dev_valid,
  output logic dev_ready,
  input wire logic [WIDTH-1:0] dev_data,
  input wire logic stall
);
  logic [WIDTH-1:0] tx_q[$];
  logic [WIDTH-1:0] rx_q[$];
  int taken_n = 0;
  logic took;
  initial
  begin
    mem_valid = 1'b0;
    mem_last = 1'b0;
    mem_data = '0;
    dev_ready = 1'b0;
  end
  always @(posedge clk_sys)
  begin
    took = mem_valid && mem_ready && rst_b;
    if (dev_valid && dev_ready && rst_b)
      rx_q.push_back(dev_data);
    #1;
    if (took && tx_q.size() > 0)
    begin
      tx_q.delete(0);
      taken_n++;
    end
    // word held until taken; an idle bus inverts its data every cycle
    if (tx_q.size() > 0)
    begin
      mem_valid = 1'b1;
      mem_data = tx_q[0];
      mem_last = (tx_q.size() == 1);
    end
    else
    begin
      mem_valid = 1'b0;
      mem_last = 1'b0;
      mem_data = ~mem_data;
    end
    dev_ready = !stall;
  end
endmodule

//--- verification/dma_channel_control_status_tb_top.sv
// self-checking bench for the dma channel control and status block
`timescale 1ns/100ps
module dma_channel_control_status_tb_top
  import dma_ctl_pkg::*;
;
  localparam int DEPTH = 16;
  logic clk_sys, rst_b, reg_wr, reg_rd, mem_valid, mem_ready, mem_last;
  logic mem_err, dev_valid, dev_ready, dev_err, device_request_line;
  logic op_bus_err, stall, rnd_stall, completion_irq_enable, completion_irq;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd, v, r, seed, mem_data, dev_data;
  logic [1:0] mem_err_code, dev_err_code, port_width_field;
  logic [2:0] retry_limit_field;
  logic [3:0] address_step_field;
  logic [31:0] exp_q[$];
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;

  dma_channel_control_status #(.DEPTH(DEPTH), .LONG_DELAY(64)) DUT (
    .clk_sys, .rst_b, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .mem_valid, .mem_ready, .mem_data, .mem_last, .mem_err, .mem_err_code,
    .dev_valid, .dev_ready, .dev_data, .dev_err, .dev_err_code,
    .device_request_line, .op_bus_err, .retry_limit_field,
    .address_step_field, .port_width_field, .completion_irq_enable,
    .completion_irq);

  stream_partner P (
    .clk_sys, .rst_b, .mem_valid, .mem_ready, .mem_data, .mem_last,
    .dev_valid, .dev_ready, .dev_data, .stall);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    // idle cycle: back-to-back calls never retoggle a strobe at once
    tick(1);
  endtask
  task automatic rdr(input logic [11:0] a);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    rd = reg_rdata;
    tick(1);
  endtask
  // polling bounded: a hung engine shows up as a failed compare
  task automatic wait_done;
    for (int i = 0; i < 400; i++)
    begin
      rdr(OFF_STATE);
      if (rd[ST_COMPLETE] === 1'b1)
        break;
    end
  endtask
  task automatic print_verdict;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cycles++;
    if (rnd_stall)
    begin
      r = xs();
      #1 stall = r[0];
    end
  end
  always @(posedge clk_sys)
    if (cycles >= 20000)
    begin
      errors++;
      print_verdict;
    end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    rst_b = 1'b0;
    seed = 32'h4;
    {reg_wr, reg_rd, mem_err, dev_err, op_bus_err} = 5'h0;
    {stall, rnd_stall, completion_irq_enable, device_request_line} = 4'h0;
    {reg_addr, reg_wdata, mem_err_code, dev_err_code} = 48'h0;
    tick(3);
    rst_b = 1'b1;
    tick(2);
    rdr(OFF_CONFIG);
    check(rd, CFG_RESET);
    check({30'h0, port_width_field}, 32'h2);
    rdr(OFF_STATE);
    check(rd, 32'h0);
    rdr(OFF_COMMAND);
    check(rd, CMD_FIXED);
    rdr(12'h504);
    check(rd, 32'h0);
    v = (xs() & 32'h00f8_3c00) | 32'h0000_0300;
    wr(OFF_CONFIG, v);
    rdr(OFF_CONFIG);
    check(rd, v | 32'h41);
    check({29'h0, retry_limit_field}, {29'h0, v[23:21]});
    check({28'h0, address_step_field}, {28'h0, v[13:10]});
    check({30'h0, port_width_field}, 32'h3);
    // full transfer, receiver stalled until the buffers refuse
    device_request_line = 1'b1;
    stall = 1'b1;
    repeat (20)
    begin
      v = xs();
      exp_q.push_back(v);
      P.tx_q.push_back(v);
    end
    wr(OFF_COMMAND, 32'h1 << CMD_START);
    rdr(OFF_COMMAND);
    check(rd, CMD_FIXED | 32'h1);
    tick(30);
    check({31'h0, mem_ready}, 32'h0);
    check(P.taken_n, DEPTH + 2);
    rnd_stall = 1'b1;
    wait_done;
    rnd_stall = 1'b0;
    check(rd, 32'h0200_0040);
    tick(2);
    // random stall left at its last value would block later drains
    stall = 1'b0;
    check(P.rx_q.size(), 20);
    foreach (exp_q[i])
      check(P.rx_q[i], exp_q[i]);
    completion_irq_enable = 1'b1;
    tick(2);
    check({31'h0, completion_irq}, 32'h1);
    wr(OFF_COMMAND, 32'h1 << CMD_CLEAR_COMPLETE);
    rdr(OFF_STATE);
    check(rd, 32'h40);
    tick(1);
    check({31'h0, completion_irq}, 32'h0);
    // each nonzero error code from each side
    for (int c = 1; c < 4; c++)
      for (int s = 0; s < 2; s++)
      begin
        wr(OFF_COMMAND, 32'h1 << CMD_START);
        rdr(OFF_STATE);
        check(rd, 32'h40);
        mem_err_code = c[1:0];
        dev_err_code = c[1:0];
        mem_err = (s == 0);
        dev_err = (s == 1);
        tick(1);
        {mem_err, dev_err} = 2'h0;
        tick(3);
        rdr(OFF_STATE);
        check(rd, 32'h0200_8240 | (c << (2 - 2 * s)));
        tick(5);
        rdr(OFF_STATE);
        check(rd, 32'h0200_8240 | (c << (2 - 2 * s)));
      end
    // bus error on a fifo operation does not end the run
    P.rx_q.delete();
    wr(OFF_COMMAND, 32'h1 << CMD_START);
    op_bus_err = 1'b1;
    tick(1);
    op_bus_err = 1'b0;
    tick(3);
    rdr(OFF_STATE);
    check(rd, 32'h440);
    P.tx_q.push_back(xs());
    wait_done;
    check({31'h0, rd[ST_COMPLETE]}, 32'h1);
    // abort while the receiver stalls
    P.rx_q.delete();
    stall = 1'b1;
    repeat (10) P.tx_q.push_back(xs());
    wr(OFF_COMMAND, 32'h1 << CMD_START);
    tick(2);
    wr(OFF_COMMAND, 32'h1 << CMD_ABORT);
    rdr(OFF_STATE);
    check(rd & 32'h4000, 32'h4000);
    rdr(OFF_COMMAND);
    check(rd & 32'h8, 32'h8);
    P.tx_q.delete();
    stall = 1'b0;
    wait_done;
    check({31'h0, P.rx_q.size() <= 2}, 32'h1);
    // stop: fifo drains, completion interrupt marks the halt
    P.rx_q.delete();
    n = P.taken_n;
    stall = 1'b1;
    repeat (10) P.tx_q.push_back(xs());
    wr(OFF_COMMAND, 32'h1 << CMD_START);
    rdr(OFF_COMMAND);
    check(rd, CMD_FIXED | 32'h1);
    wr(OFF_COMMAND, 32'h1 << CMD_STOP);
    rdr(OFF_STATE);
    check(rd & ~32'hc00, 32'h1040);
    check({31'h0, completion_irq}, 32'h0);
    P.tx_q.delete();
    stall = 1'b0;
    wait_done;
    tick(2);
    check({31'h0, completion_irq}, 32'h1);
    check(P.rx_q.size(), P.taken_n - n);
    // flush and whole-engine reset
    wr(OFF_COMMAND, 32'h1 << CMD_FIFO_FLUSH);
    tick(2);
    rdr(OFF_COMMAND);
    // stop stays written until the next start or engine reset
    check(rd, CMD_FIXED | (32'h1 << CMD_STOP));
    wr(OFF_CONFIG, 32'h00f8_3f00);
    device_request_line = 1'b0;
    wr(OFF_COMMAND, 32'h1 << CMD_ENGINE_RESET);
    tick(3);
    rdr(OFF_CONFIG);
    check(rd, CFG_RESET);
    rdr(OFF_STATE);
    check(rd, 32'h0);
    // request pacing: low request line holds words, then limited rate
    P.rx_q.delete();
    repeat (3) P.tx_q.push_back(xs());
    wr(OFF_COMMAND, 32'h1 << CMD_START);
    tick(20);
    check(P.rx_q.size(), 0);
    wr(OFF_CONFIG, 32'h0009_0300);
    tick(20);
    check(P.rx_q.size(), 1);
    wait_done;
    check(P.rx_q.size(), 3);
    print_verdict;
  end
endmodule
